// File: verilog/self_program_page_pkg.sv
package self_program_page_pkg;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] POINTER_OFFSET = 8'h04;
  localparam logic [7:0] DATA_OFFSET    = 8'h08;
  localparam logic [7:0] STORE_OFFSET   = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET  = 8'h10;
  localparam logic [7:0] BUFREAD_OFFSET = 8'h14;

  // control register fields
  localparam int CTRL_IRQ_EN_BIT = 7;
  localparam int CTRL_BUSY_BIT   = 6;
  localparam int CMD_WIDTH       = 5;

  // low five-bit command patterns
  localparam logic [4:0] CMD_LOAD     = 5'h01;
  localparam logic [4:0] CMD_ERASE    = 5'h03;
  localparam logic [4:0] CMD_WRITE    = 5'h05;
  localparam logic [4:0] CMD_LOCK_SET = 5'h09;
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [4:0] CMD_IDLE     = 5'h00;

  // pointer layout: bit 0 ignored, word index, then page index
  localparam int PTR_WIDTH  = 16;
  localparam int WORD_LSB   = 1;
  localparam int WORD_WIDTH = 5;
  localparam int PAGE_LSB   = 6;
  localparam int PAGE_WIDTH = 7;
  localparam int BUF_WORDS  = 32;
  localparam int DATA_WIDTH = 16;

  // first page of the non-concurrent section
  localparam logic [6:0] NONCONC_FIRST_PAGE = 7'h60;

  // store must follow the control write within this many cycles
  localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;

  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;

endpackage : self_program_page_pkg

// File: verilog/self_program_page_sequencer.sv
// Behaviour
// - pages erased before programmed; whole pages only
// - buffer loaded per store, before/after erase
// - buffer words writable in any order
// - erase pattern plus store within four cycles
// - erase of concurrent section keeps other readable
// - non-concurrent target halts processor until done
// - load pattern stores data pair at word
// - buffer clears after write, reenable, reset
// - eeprom write discards loaded buffer data
// - write pattern plus store starts page write
// - write to concurrent section keeps other readable
// - enabled ready interrupt while arm bit clear
// - concurrent section blocked during erase/write
// - busy bit set while concurrent section busy
// - arm bit held during operation, then clears
// - no store in four cycles cancels command
// - new page load clears busy bit
// - undefined command patterns have no effect
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module self_program_page_sequencer (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        eeprom_write,
  input  wire logic        flash_done,
  input  wire logic [4:0]  flash_word_idx,
  output logic      [15:0] flash_word_data,
  output logic             flash_erase_req,
  output logic             flash_write_req,
  output logic      [6:0]  flash_page,
  output logic             cpu_halt,
  output logic             concurrent_read_block,
  output logic             ready_irq
);

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [31:0] prdata_r,      prdata_nxt;
  logic        pready_r,      pready_nxt;
  logic        pslverr_r,     pslverr_nxt;
  logic [4:0]  cmd_r,         cmd_nxt;
  logic        irq_en_r,      irq_en_nxt;
  logic        busy_r,        busy_nxt;
  logic [2:0]  arm_cnt_r,     arm_cnt_nxt;
  logic [15:0] pointer_r,     pointer_nxt;
  logic [15:0] data_pair_r,   data_pair_nxt;
  logic        op_active_r,   op_active_nxt;
  logic        op_is_write_r, op_is_write_nxt;
  logic [6:0]  page_r,        page_nxt;
  logic        erase_req_r,   erase_req_nxt;
  logic        write_req_r,   write_req_nxt;
  logic        halt_r,        halt_nxt;
  logic        irq_r,         irq_nxt;
  logic [31:0] valid_r,       valid_nxt;
  logic [15:0] word_out_r;

  logic [15:0] buf_mem [0:self_program_page_pkg::BUF_WORDS-1];
  logic        buf_we;
  logic [4:0]  buf_idx;

  logic        access;
  logic        wr;
  logic        mapped;
  logic        cmd_legal;
  logic [6:0]  ptr_page;
  logic [4:0]  ptr_word;
  logic [7:0]  ctrl_view;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  always_comb begin
    ptr_page = pointer_r[self_program_page_pkg::PAGE_LSB +:
                         self_program_page_pkg::PAGE_WIDTH];
    ptr_word = pointer_r[self_program_page_pkg::WORD_LSB +:
                         self_program_page_pkg::WORD_WIDTH];
    ctrl_view = {irq_en_r, busy_r, 1'b0, cmd_r};
    mapped = (paddr == self_program_page_pkg::CTRL_OFFSET)    ||
             (paddr == self_program_page_pkg::POINTER_OFFSET) ||
             (paddr == self_program_page_pkg::DATA_OFFSET)    ||
             (paddr == self_program_page_pkg::STORE_OFFSET)   ||
             (paddr == self_program_page_pkg::STATUS_OFFSET)  ||
             (paddr == self_program_page_pkg::BUFREAD_OFFSET);
    cmd_legal = (pwdata[4:0] == self_program_page_pkg::CMD_LOAD)     ||
                (pwdata[4:0] == self_program_page_pkg::CMD_ERASE)    ||
                (pwdata[4:0] == self_program_page_pkg::CMD_WRITE)    ||
                (pwdata[4:0] == self_program_page_pkg::CMD_LOCK_SET) ||
                (pwdata[4:0] == self_program_page_pkg::CMD_REENABLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    access          = psel & penable & pready_r;
    wr              = access & pwrite;
    prdata_nxt      = self_program_page_pkg::RESET_WORD;
    pready_nxt      = psel & penable & ~pready_r;
    pslverr_nxt     = psel & penable & ~pready_r & ~mapped;
    cmd_nxt         = cmd_r;
    irq_en_nxt      = irq_en_r;
    busy_nxt        = busy_r;
    arm_cnt_nxt     = arm_cnt_r;
    pointer_nxt     = pointer_r;
    data_pair_nxt   = data_pair_r;
    op_active_nxt   = op_active_r;
    op_is_write_nxt = op_is_write_r;
    page_nxt        = page_r;
    erase_req_nxt   = 1'b0;
    write_req_nxt   = 1'b0;
    halt_nxt        = halt_r;
    valid_nxt       = valid_r;
    buf_we          = 1'b0;
    buf_idx         = ptr_word;

    // one wait state; read data is captured as pready rises
    if (psel && penable && !pready_r && !pwrite) begin
      unique case (paddr)
        self_program_page_pkg::CTRL_OFFSET:
          prdata_nxt = {24'h00_0000, ctrl_view};
        self_program_page_pkg::POINTER_OFFSET:
          prdata_nxt = {16'h0000, pointer_r};
        self_program_page_pkg::DATA_OFFSET:
          prdata_nxt = {16'h0000, data_pair_r};
        self_program_page_pkg::STATUS_OFFSET:
          prdata_nxt = {29'h0000_0000, halt_r, op_is_write_r, op_active_r};
        self_program_page_pkg::BUFREAD_OFFSET:
          prdata_nxt = {16'h0000, valid_r[ptr_word] ? buf_mem[ptr_word]
                                  : self_program_page_pkg::ERASED_WORD};
        default:
          prdata_nxt = self_program_page_pkg::RESET_WORD;
      endcase
    end

    // arm window runs out with no store
    if (arm_cnt_r != 3'h0) begin
      arm_cnt_nxt = arm_cnt_r - 3'h1;
      if (arm_cnt_r == 3'h1 && !op_active_r) begin
        cmd_nxt = self_program_page_pkg::CMD_IDLE;
      end
    end

    // flash macro finished an erase or write
    if (op_active_r && flash_done) begin
      op_active_nxt = 1'b0;
      cmd_nxt       = self_program_page_pkg::CMD_IDLE;
      halt_nxt      = 1'b0;
      if (op_is_write_r) begin
        valid_nxt = 32'h0000_0000;
      end
    end

    // eeprom write in mid-load loses the buffer
    if (eeprom_write) begin
      valid_nxt = 32'h0000_0000;
    end

    if (wr) begin
      unique case (paddr)
        self_program_page_pkg::CTRL_OFFSET: begin
          irq_en_nxt = pwdata[self_program_page_pkg::CTRL_IRQ_EN_BIT];
          // arm bit stays high through an operation
          if (cmd_legal && !op_active_r) begin
            cmd_nxt     = pwdata[4:0];
            arm_cnt_nxt = self_program_page_pkg::ARM_WINDOW_CYCLES;
          end
        end
        self_program_page_pkg::POINTER_OFFSET:
          pointer_nxt = pwdata[15:0];
        self_program_page_pkg::DATA_OFFSET:
          data_pair_nxt = pwdata[15:0];
        self_program_page_pkg::STORE_OFFSET: begin
          if (arm_cnt_r != 3'h0 && !op_active_r) begin
            arm_cnt_nxt = 3'h0;
            cmd_nxt     = self_program_page_pkg::CMD_IDLE;
            unique case (cmd_r)
              self_program_page_pkg::CMD_LOAD: begin
                // any word, any order; later load overrides clears
                buf_we             = 1'b1;
                valid_nxt[ptr_word] = 1'b1;
                busy_nxt           = 1'b0;
              end
              self_program_page_pkg::CMD_ERASE,
              self_program_page_pkg::CMD_WRITE: begin
                // erase and write each act on a whole page
                cmd_nxt         = cmd_r;
                op_active_nxt   = 1'b1;
                op_is_write_nxt = (cmd_r == self_program_page_pkg::CMD_WRITE);
                page_nxt        = ptr_page;
                erase_req_nxt   = (cmd_r == self_program_page_pkg::CMD_ERASE);
                write_req_nxt   = (cmd_r == self_program_page_pkg::CMD_WRITE);
                if (ptr_page >=
                    self_program_page_pkg::NONCONC_FIRST_PAGE) begin
                  halt_nxt = 1'b1;
                end else begin
                  // non-concurrent side stays readable: no halt
                  busy_nxt = 1'b1;
                end
              end
              self_program_page_pkg::CMD_REENABLE: begin
                busy_nxt  = 1'b0;
                valid_nxt = 32'h0000_0000;
              end
              default: begin
                // lock setting not supported: command is consumed
                cmd_nxt = self_program_page_pkg::CMD_IDLE;
              end
            endcase
          end
        end
        default: ;
      endcase
    end

    irq_nxt = irq_en_nxt & ~cmd_nxt[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r      <= self_program_page_pkg::RESET_WORD;
      pready_r      <= 1'b0;
      pslverr_r     <= 1'b0;
      cmd_r         <= self_program_page_pkg::CMD_IDLE;
      irq_en_r      <= 1'b0;
      busy_r        <= 1'b0;
      arm_cnt_r     <= 3'h0;
      pointer_r     <= 16'h0000;
      data_pair_r   <= 16'h0000;
      op_active_r   <= 1'b0;
      op_is_write_r <= 1'b0;
      page_r        <= 7'h00;
      erase_req_r   <= 1'b0;
      write_req_r   <= 1'b0;
      halt_r        <= 1'b0;
      irq_r         <= 1'b0;
      valid_r       <= 32'h0000_0000;
      word_out_r    <= self_program_page_pkg::ERASED_WORD;
    end else begin
      prdata_r      <= prdata_nxt;
      pready_r      <= pready_nxt;
      pslverr_r     <= pslverr_nxt;
      cmd_r         <= cmd_nxt;
      irq_en_r      <= irq_en_nxt;
      busy_r        <= busy_nxt;
      arm_cnt_r     <= arm_cnt_nxt;
      pointer_r     <= pointer_nxt;
      data_pair_r   <= data_pair_nxt;
      op_active_r   <= op_active_nxt;
      op_is_write_r <= op_is_write_nxt;
      page_r        <= page_nxt;
      erase_req_r   <= erase_req_nxt;
      write_req_r   <= write_req_nxt;
      halt_r        <= halt_nxt;
      irq_r         <= irq_nxt;
      valid_r       <= valid_nxt;
      // cleared words read as erased, so no array wipe is needed
      word_out_r    <= valid_r[flash_word_idx] ? buf_mem[flash_word_idx]
                       : self_program_page_pkg::ERASED_WORD;
    end
  end

  // buffer storage has no reset; the valid mask stands in for it
  always_ff @(posedge mclk) begin
    if (buf_we) begin
      buf_mem[buf_idx] <= data_pair_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata                = prdata_r;
  assign pready                = pready_r;
  assign pslverr               = pslverr_r;
  assign flash_word_data       = word_out_r;
  assign flash_erase_req       = erase_req_r;
  assign flash_write_req       = write_req_r;
  assign flash_page            = page_r;
  assign cpu_halt              = halt_r;
  assign concurrent_read_block = busy_r;
  assign ready_irq             = irq_r;

endmodule : self_program_page_sequencer

`default_nettype wire

// File: testbench/self_program_page_props.sv
`timescale 1ns/10ps
`default_nettype none
module self_program_page_props (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       flash_done,
  input wire logic       flash_erase_req,
  input wire logic       flash_write_req,
  input wire logic [6:0] flash_page,
  input wire logic       cpu_halt,
  input wire logic       concurrent_read_block,
  input wire logic       ready_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic go;
  logic hi;
  assign go = flash_erase_req | flash_write_req;
  assign hi = flash_page >= self_program_page_pkg::NONCONC_FIRST_PAGE;
  ////////////////////////////////////////
  property p_ack; $rose(penable) && psel |-> !pready ##1 pready; endproperty
  a_ack: assert property (p_ack)
    else $error("apb answer not after one wait");
  property p_pulse; go |=> !go; endproperty
  a_pulse: assert property (p_pulse)
    else $error("flash request longer than a cycle");
  property p_halt; go |-> cpu_halt == hi; endproperty
  a_halt: assert property (p_halt)
    else $error("halt does not follow target section");
  property p_block; go && !hi |-> concurrent_read_block; endproperty
  a_block: assert property (p_block)
    else $error("concurrent section not blocked");
  property p_hold; cpu_halt && !flash_done |=> cpu_halt; endproperty
  a_hold: assert property (p_hold)
    else $error("halt dropped before completion");
  property p_rel; cpu_halt && flash_done |=> !cpu_halt; endproperty
  a_rel: assert property (p_rel)
    else $error("halt kept after completion");
  property p_busy; concurrent_read_block && !pready |=> concurrent_read_block;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy cleared without a command");
  property p_irq; go || cpu_halt |-> !ready_irq; endproperty
  a_irq: assert property (p_irq)
    else $error("ready interrupt during operation");
  property p_page; cpu_halt && !go |-> $stable(flash_page); endproperty
  a_page: assert property (p_page)
    else $error("page moved during operation");
  c_hi_erase: cover property (flash_erase_req && hi);
  c_lo_write: cover property (flash_write_req && !hi);
  c_irq: cover property ($rose(ready_irq));
endmodule : self_program_page_props
bind self_program_page_sequencer self_program_page_props u_props (
  .mclk, .reset_n, .psel, .penable, .pready, .flash_done, .flash_erase_req,
  .flash_write_req, .flash_page, .cpu_halt, .concurrent_read_block, .ready_irq);
`default_nettype wire

// File: testbench/flash_macro_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_macro_model (
  input  wire logic        mclk,
  input  wire logic        erase_req,
  input  wire logic        write_req,
  input  wire logic [15:0] word_data,
  input  wire logic [7:0]  slow_cycles,
  output logic      [4:0]  word_idx,
  output logic             done
);
  logic [15:0] img [32];
  logic        wr;
  initial begin
    word_idx = 5'h0;
    done = 1'b0;
    forever begin
      @(posedge mclk);
      if (erase_req || write_req) begin
        wr = write_req;
        // word data lags the index by two edges
        for (int i = 0; i < 34; i++) begin
          if (wr && i >= 2) img[i-2] = word_data;
          word_idx <= i[4:0];
          @(posedge mclk);
        end
        repeat (slow_cycles) @(posedge mclk);
        done <= 1'b1;
        @(posedge mclk);
        done <= 1'b0;
      end else
        word_idx <= word_idx + 5'h1; // idle index never looks settled
    end
  end
endmodule : flash_macro_model
`default_nettype wire

// File: testbench/self_program_page_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module self_program_page_sequencer_tb_top;
  logic        mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, eeprom_write = 1'b0, irq = 1'b0, rd_e;
  logic        pready, pslverr, flash_done, flash_erase_req, flash_write_req;
  logic        cpu_halt, concurrent_read_block, ready_irq;
  logic [7:0]  paddr = 8'h0, slow_cycles = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [4:0]  flash_word_idx;
  logic [15:0] flash_word_data, exp_buf [32];
  logic [6:0]  flash_page;
  int          mismatches = 0, check_count = 0;
  always #20 mclk = ~mclk;
  self_program_page_sequencer dut (.mclk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .eeprom_write, .flash_done,
    .flash_word_idx, .flash_word_data, .flash_erase_req, .flash_write_req,
    .flash_page, .cpu_halt, .concurrent_read_block, .ready_irq);
  flash_macro_model fm (.mclk, .erase_req(flash_erase_req), .slow_cycles,
    .write_req(flash_write_req), .word_data(flash_word_data),
    .word_idx(flash_word_idx), .done(flash_done));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chkb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : chkb
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic ctl(input logic [4:0] c);
    apb(1'b1, self_program_page_pkg::CTRL_OFFSET, {24'h0, irq, 2'h0, c});
  endtask : ctl
  task automatic rdc(input logic [6:0] e);
    apb(1'b0, self_program_page_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl", {24'h0, irq, e}, rd_q);
  endtask : rdc
  task automatic store;
    apb(1'b1, self_program_page_pkg::STORE_OFFSET, 32'hFFFF_FFFF);
  endtask : store
  task automatic clear_exp;
    foreach (exp_buf[i]) exp_buf[i] = 16'hFFFF;
  endtask : clear_exp
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    clear_exp();
    @(posedge mclk);
  endtask : do_reset
  task automatic bufchk(input logic [4:0] w);
    apb(1'b1, self_program_page_pkg::POINTER_OFFSET, {26'h0, w, 1'b0});
    apb(1'b0, self_program_page_pkg::BUFREAD_OFFSET, 32'h0);
    chk("buffer word", {16'h0, exp_buf[w]}, rd_q);
  endtask : bufchk
  // gap 0 lands the store on the last armed edge, gap 1 one edge late
  task automatic load(input logic [4:0] w, input logic [15:0] d,
                      input int gap);
    apb(1'b1, self_program_page_pkg::POINTER_OFFSET, {26'h0, w, 1'b1});
    apb(1'b1, self_program_page_pkg::DATA_OFFSET, {16'h5A5A, d});
    apb(1'b0, self_program_page_pkg::DATA_OFFSET, 32'h0);
    chk("data pair", {16'h0, d}, rd_q);
    ctl(self_program_page_pkg::CMD_LOAD);
    repeat (gap) @(posedge mclk);
    store();
    if (gap < 1) exp_buf[w] = d;
  endtask : load
  task automatic op(input logic [4:0] c, input logic [6:0] pg);
    logic lo;
    lo = pg < self_program_page_pkg::NONCONC_FIRST_PAGE;
    apb(1'b1, self_program_page_pkg::POINTER_OFFSET,
        {19'h0, pg, 6'h0});
    ctl(c);
    store();
    if (lo) rdc({2'h2, c});
    apb(1'b0, self_program_page_pkg::STATUS_OFFSET, 32'h0);
    chk("status", {29'h0, !lo, c == self_program_page_pkg::CMD_WRITE, 1'b1},
        rd_q);
    // bench never fetches from the concurrent section while busy
    // ready_irq is only watched, never serviced mid-operation
    chkb("halt", !lo, cpu_halt);
    chkb("block", lo, concurrent_read_block);
    chk("page", {25'h0, pg}, {25'h0, flash_page});
    do @(posedge mclk); while (flash_done !== 1'b1);
    @(negedge mclk);
    chkb("halt end", 1'b0, cpu_halt);
    chkb("irq end", irq, ready_irq);
    @(posedge mclk);
    if (c == self_program_page_pkg::CMD_WRITE) begin
      foreach (exp_buf[i])
        chk("image", {16'h0, exp_buf[i]}, {16'h0, fm.img[i]});
      clear_exp();
    end
  endtask : op
  ////////////////////////////////////////
  task automatic t_reset;
    load(5'h03, 16'h1234, 0);
    do_reset();
    bufchk(5'h03);
    rdc(7'h0);
    apb(1'b0, 8'h18, 32'h0);
    chkb("unmapped error", 1'b1, rd_e);
    chk("word after reset", 32'h0000_FFFF, {16'h0, flash_word_data});
    $display("test done: reset");
  endtask : t_reset
  task automatic t_cmds;
    irq = 1'b1;
    for (int c = 0; c < 32; c++) begin
      if (c inside {1, 3, 5, 9, 17}) continue;
      ctl(c[4:0]);
      rdc(7'h0);
    end
    ctl(self_program_page_pkg::CMD_LOCK_SET);
    store();
    rdc(7'h0);
    chkb("irq idle", 1'b1, ready_irq);
    $display("test done: undefined commands");
  endtask : t_cmds
  task automatic t_window;
    ctl(self_program_page_pkg::CMD_LOAD);
    @(negedge mclk);
    chkb("irq armed", 1'b0, ready_irq);
    repeat (4) @(posedge mclk);
    rdc(7'h0);
    load(5'h07, 16'hBEEF, 0);
    load(5'h08, 16'hCAFE, 1);
    bufchk(5'h07);
    bufchk(5'h08);
    eeprom_write <= 1'b1;
    @(posedge mclk) eeprom_write <= 1'b0;
    clear_exp();
    bufchk(5'h07);
    $display("test done: arming window");
  endtask : t_window
  task automatic t_low;
    op(self_program_page_pkg::CMD_ERASE, 7'h10);
    load(5'h1F, 16'h0F1E, 0);
    load(5'h00, 16'h7001, 0);
    load(5'h0A, 16'h1A2B, 0);
    bufchk(5'h1F);
    op(self_program_page_pkg::CMD_WRITE, 7'h10);
    bufchk(5'h1F);
    rdc(7'h40);
    $display("test done: low page");
  endtask : t_low
  task automatic t_high;
    slow_cycles <= 8'h28;
    load(5'h02, 16'h2222, 0);
    rdc(7'h0);
    ctl(self_program_page_pkg::CMD_REENABLE);
    store();
    clear_exp();
    bufchk(5'h02);
    load(5'h02, 16'h3333, 0);
    load(5'h11, 16'h4444, 0);
    op(self_program_page_pkg::CMD_ERASE, 7'h7F);
    op(self_program_page_pkg::CMD_WRITE, 7'h7F);
    $display("test done: high page");
  endtask : t_high
  ////////////////////////////////////////
  initial begin
    do_reset();
    t_reset();
    t_cmds();
    t_window();
    t_low();
    t_high();
    close_out();
  end
  // more than twenty times the longest expected run
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("watchdog expired");
    close_out();
  end
endmodule : self_program_page_sequencer_tb_top
`default_nettype wire
